// >>> verilog/sero_defines.svh
// Constants of the serial EEPROM target: address pattern, bit counts, sizes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SERO_DEFINES_SVH
`define SERO_DEFINES_SVH
`define SERO_DEV_TYPE   4'ha
`define SERO_BITS_WORD  4'd8
`define SERO_ADDR_W     11
`define SERO_PAGE_W     4
`define SERO_SEL_W      3
`endif

// >>> verilog/sero_pkg.sv
// Types shared by the serial EEPROM target.
// Assumes nothing beyond the constants header.
`include "sero_defines.svh"
package sero_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_RX_DEV, ST_ACK_DEV, ST_RX_WORD, ST_ACK_WORD,
		ST_RX_DATA, ST_ACK_DATA, ST_TX, ST_TX_ACK, ST_TX_MORE
	} sero_state_t;
	typedef logic [`SERO_SEL_W-1:0] sero_sel_t;
endpackage : sero_pkg

// >>> verilog/sero_buf2.sv
// Two-entry valid/ready buffer between array fetch and the serial shifter.
// Assumes both sides on the one system clock.
`timescale 1ns/1ns
`default_nettype none
module sero_buf2 #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] slot_reg [2];
	logic         wr_ptr_reg;
	logic         rd_ptr_reg;
	logic [1:0]   count_reg;
	logic         push;
	logic         pop;

	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data  = slot_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// ****************************************
	// Storage and pointers
	// ****************************************
	always_ff @(posedge clock) begin
		if (push) begin
			slot_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 2'h1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end

	no_overflow_a: assert property (@(posedge clock) disable iff (!rstn)
		count_reg != 2'h3) else $error("buffer count out of range");
endmodule : sero_buf2
`default_nettype wire

// >>> verilog/sero_target.sv
// Two-wire serial EEPROM target: addressing, dummy write, reads, counter.
// Assumes scl and sda arrive asynchronously and far slower than the clock.
`timescale 1ns/1ns
`default_nettype none
`include "sero_defines.svh"
// Notes on behaviour
// RL1: Controller starts reads with direction bit one.
// RL2: Counter holds last accessed address plus one.
// RL3: Counter keeps value between transactions.
// RL4: Read increment wraps array end to zero.
// RL5: Write increment wraps within current page.
// RL6: Current read shifts out byte at counter.
// RL7: Controller ends single read with nack, stop.
// RL8: Dummy write loads counter with word address.
// RL9: Controller repeats start, sends read address.
// RL10: Random read returns byte at loaded address.
// RL11: Controller acks each byte it still wants.
// RL12: Acked read byte increments counter, sends next.
// RL13: Sequential read wraps past top to zero.
// RL14: Controller ends sequential read with nack, stop.
// RL15: Eight-bit words, ack low on ninth clock.
// RL16: Device type pattern must match to respond.
// RL17: Detect start and stop while clock high.
// RL18: Page-select bits are word address MSBs.
// RL19: Release line on ninth clock; nack idles.
module sero_target #(
	parameter int ADDR_W = `SERO_ADDR_W,
	parameter int PAGE_W = `SERO_PAGE_W
) (
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire sero_pkg::sero_sel_t sel_pins
);
	import sero_pkg::*;

	localparam int PSEL = (ADDR_W > 8) ? ADDR_W - 8 : 0;
	localparam sero_sel_t PMASK = sero_sel_t'((1 << PSEL) - 1);

	generate
		if (ADDR_W < 7 || ADDR_W > 11 || PAGE_W < 1 || PAGE_W >= ADDR_W) begin : bad_cfg
			$error("sero_target: unsupported ADDR_W or PAGE_W");
		end
	endgenerate

	// Select pins used as page bits are ignored in the compare
	function automatic logic dev_match(input logic [7:0] dev, input sero_sel_t pins);
		dev_match = (dev[7:4] == `SERO_DEV_TYPE) && (((dev[3:1] ^ pins) & ~PMASK) == '0);
	endfunction : dev_match

	sero_state_t        state_reg;
	logic [3:0]         cnt_reg;
	logic [7:0]         shreg_reg;
	logic               rw_reg;
	sero_sel_t          page_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic [7:0]         mem_reg [1<<ADDR_W];
	logic [7:0]         tx_reg;
	logic [2:0]         scl_sync_reg;
	logic [2:0]         sda_sync_reg;
	sero_sel_t          sel_meta_reg;
	sero_sel_t          sel_sync_reg;
	logic               scl_s;
	logic               sda_s;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_det;
	logic               stop_det;
	logic               rx_state;
	logic               ack_state;
	logic               dev_done;
	logic               dev_hit;
	logic               word_done;
	logic               data_done;
	logic               ack_end;
	logic               byte_end;
	logic               more;
	logic               fetch;
	logic               fetch_ok;
	logic               pop;
	logic               buf_in_ready;
	logic               buf_out_valid;
	logic [7:0]         buf_out_data;
	logic [ADDR_W-1:0]  load_addr;

	// ****************************************
	// Pin synchronisers and bus events
	// ****************************************
	// Stage 0 feeds stage 1 only; stage 2 is the previous sample for edges
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			sel_meta_reg <= '0;
			sel_sync_reg <= '0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			sel_meta_reg <= sel_pins;
			sel_sync_reg <= sel_meta_reg;
		end
	end

	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s && !scl_sync_reg[2];
	assign scl_fall  = !scl_s && scl_sync_reg[2];
	assign start_det = scl_s && scl_sync_reg[2] && !sda_s && sda_sync_reg[2]; // RL17
	assign stop_det  = scl_s && scl_sync_reg[2] && sda_s && !sda_sync_reg[2]; // RL17

	assign rx_state  = (state_reg == ST_RX_DEV) || (state_reg == ST_RX_WORD)
		|| (state_reg == ST_RX_DATA);
	assign ack_state = (state_reg == ST_ACK_DEV) || (state_reg == ST_ACK_WORD)
		|| (state_reg == ST_ACK_DATA);
	assign dev_done  = scl_fall && (state_reg == ST_RX_DEV) && (cnt_reg == `SERO_BITS_WORD);
	assign dev_hit   = dev_done && dev_match(shreg_reg, sel_sync_reg); // RL16
	assign word_done = scl_fall && (state_reg == ST_RX_WORD) && (cnt_reg == `SERO_BITS_WORD);
	assign data_done = scl_fall && (state_reg == ST_RX_DATA) && (cnt_reg == `SERO_BITS_WORD);
	assign ack_end   = scl_fall && ack_state;
	assign byte_end  = scl_fall && (state_reg == ST_TX) && (cnt_reg == `SERO_BITS_WORD);
	assign more      = scl_rise && (state_reg == ST_TX_ACK) && !sda_s; // RL12
	// Fetch happens a full clock (after the device address) or a half clock (after an ack) ahead of the shifter needing the byte
	assign fetch     = (dev_hit && shreg_reg[0]) || more;
	assign fetch_ok  = fetch && buf_in_ready;
	assign pop       = (ack_end && (state_reg == ST_ACK_DEV) && rw_reg)
		|| (scl_fall && (state_reg == ST_TX_MORE));
	// Page bits from the device address on top of the received byte
	assign load_addr = ADDR_W'({page_reg, shreg_reg}); // RL18

	// ****************************************
	// Protocol sequencer
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
			shreg_reg <= 8'h00;
			rw_reg    <= 1'b0;
			page_reg  <= '0;
		end else if (start_det) begin
			state_reg <= ST_RX_DEV; // RL17
			cnt_reg   <= 4'h0;
		end else if (stop_det) begin
			state_reg <= ST_IDLE; // RL17
		end else if (rx_state && scl_rise) begin
			shreg_reg <= {shreg_reg[6:0], sda_s}; // RL15
			cnt_reg   <= cnt_reg + 4'h1;
		end else if (dev_done) begin
			state_reg <= dev_hit ? ST_ACK_DEV : ST_IDLE; // RL16
			rw_reg    <= shreg_reg[0];
			page_reg  <= shreg_reg[3:1] & PMASK;
		end else if (word_done) begin
			state_reg <= ST_ACK_WORD;
		end else if (data_done) begin
			state_reg <= ST_ACK_DATA;
		end else if (ack_end) begin
			cnt_reg <= 4'h0;
			if (state_reg == ST_ACK_DEV) begin
				state_reg <= rw_reg ? ST_TX : ST_RX_WORD; // RL6
			end else begin
				state_reg <= ST_RX_DATA;
			end
		end else if (state_reg == ST_TX && scl_rise) begin
			cnt_reg <= cnt_reg + 4'h1;
		end else if (byte_end) begin
			state_reg <= ST_TX_ACK; // RL19
		end else if (state_reg == ST_TX_ACK && scl_rise) begin
			state_reg <= sda_s ? ST_IDLE : ST_TX_MORE; // RL19
		end else if (state_reg == ST_TX_MORE && scl_fall) begin
			state_reg <= ST_TX; // RL12
			cnt_reg   <= 4'h0;
		end
	end

	// ****************************************
	// Word address counter
	// ****************************************
	// Only touched by transfers, so it survives idle and stop
	always_ff @(posedge clock or negedge rstn) begin // RL3
		if (!rstn) begin
			addr_reg <= '0;
		end else if (word_done) begin
			addr_reg <= load_addr; // RL8
		end else if (data_done) begin
			addr_reg <= {addr_reg[ADDR_W-1:PAGE_W], addr_reg[PAGE_W-1:0] + PAGE_W'(1)}; // RL5
		end else if (fetch_ok) begin
			addr_reg <= addr_reg + ADDR_W'(1); // RL2 RL4 RL13
		end
	end

	// ****************************************
	// Array and read buffer
	// ****************************************
	// Array contents have no reset, as in a real memory
	always_ff @(posedge clock) begin
		if (data_done) begin
			mem_reg[addr_reg] <= shreg_reg;
		end
	end

	sero_buf2 #(
		.W (8)
	) u_buf (
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (fetch),
		.in_ready  (buf_in_ready),
		.in_data   (mem_reg[addr_reg]),
		.out_valid (buf_out_valid),
		.out_ready (pop),
		.out_data  (buf_out_data)
	);

	// ****************************************
	// Data line driver
	// ****************************************
	// Line changes only after a clock fall, so no false start or stop
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
			tx_reg  <= 8'h00;
		end else if (start_det || stop_det) begin
			sda_oe <= 1'b0;
		end else if (dev_hit || word_done || data_done) begin
			sda_oe <= 1'b1; // RL15
		end else if (pop) begin
			tx_reg <= buf_out_data; // RL6 RL10
			sda_oe <= buf_out_valid && !buf_out_data[7];
		end else if (ack_end || byte_end) begin
			sda_oe <= 1'b0; // RL19
		end else if (state_reg == ST_TX && scl_fall) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
			sda_oe <= !tx_reg[6];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	dev_ack_a: assert property (dev_hit |=> sda_oe && state_reg == ST_ACK_DEV) // RL15
		else $error("matched address not acknowledged");
	dev_miss_a: assert property (dev_done && !dev_hit |=> !sda_oe && state_reg == ST_IDLE) // RL16
		else $error("unmatched address answered");
	start_seen_a: assert property (start_det |=> state_reg == ST_RX_DEV && cnt_reg == 4'h0) // RL17
		else $error("start not taken");
	stop_seen_a: assert property (stop_det |=> state_reg == ST_IDLE && !sda_oe) // RL17
		else $error("stop not taken");
	read_incr_a: assert property (fetch_ok && !word_done |=>
		addr_reg == $past(addr_reg) + ADDR_W'(1)) // RL2
		else $error("read counter not incremented");
	read_wrap_a: assert property (fetch_ok && addr_reg == '1 |=> addr_reg == '0) // RL13
		else $error("read counter did not wrap to zero");
	page_wrap_a: assert property (data_done |=>
		addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W])) // RL5
		else $error("write changed page bits");
	addr_hold_a: assert property (state_reg == ST_IDLE && !fetch |=> $stable(addr_reg)) // RL3
		else $error("counter moved while idle");
	load_word_a: assert property (word_done |=> addr_reg == $past(load_addr)) // RL8
		else $error("word address not loaded");
	first_bit_a: assert property (pop && buf_out_valid |=>
		sda_oe == !$past(buf_out_data[7])) // RL6
		else $error("first data bit wrong");
	release_a: assert property (byte_end |=> !sda_oe ##0 state_reg == ST_TX_ACK) // RL19
		else $error("line not released for ack");
	nack_idle_a: assert property (state_reg == ST_TX_ACK && scl_rise && sda_s
		&& !start_det && !stop_det |=> state_reg == ST_IDLE) // RL19
		else $error("nack did not end read");

	cov_current_read_c: cover property (dev_hit && shreg_reg[0]);
	cov_random_read_c: cover property (word_done ##[1:1000] (dev_hit && shreg_reg[0]));
	cov_seq_wrap_c: cover property (more && addr_reg == '1);
	cov_page_wrap_c: cover property (data_done && addr_reg[PAGE_W-1:0] == '1);
endmodule : sero_target
`default_nettype wire

// >>> testbench/sero_ctrl_model.sv
// Bus controller model: owns the serial clock, pulls the data line low.
// Assumes a pull-up outside resolves the data line to high when released.
`timescale 1ns/1ns
`default_nettype none
module sero_ctrl_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// ************
	// Bus primitives
	// ************
	// Clock stands high between frames; timing free of the system clock
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Non-blocking, so a change on a clock edge is seen one edge later
	task automatic start();
		#31 sda_low <= 1'b0;
		#31 scl <= 1'b1;
		#31 sda_low <= 1'b1;
		#32 scl <= 1'b0;
	endtask : start
	task automatic stop();
		#31 sda_low <= 1'b1;
		#31 scl <= 1'b1;
		#31 sda_low <= 1'b0;
		#62;
	endtask : stop
	// Data only moves while the clock is low
	task automatic bit_xfer(input logic b, output logic r);
		#31 sda_low <= ~b;
		#31 scl <= 1'b1;
		#31 r = sda;
		#32 scl <= 1'b0;
	endtask : bit_xfer
	task automatic send_byte(input logic [7:0] v, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(v[i], r);
		end
		bit_xfer(1'b1, ack_n);
	endtask : send_byte
	task automatic recv_byte(input logic more, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, v[i]);
		end
		bit_xfer(~more, r);
	endtask : recv_byte
endmodule : sero_ctrl_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Testbench for the serial EEPROM target: writes, refused, random,
// current and wrapping sequential reads. Assumes controller model file.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import sero_pkg::*;
	localparam int AW = 9;
	logic       clock;
	logic       rstn;
	logic       scl;
	logic       sda_low;
	logic       sda_oe;
	logic       sda_out;
	wire        sda;
	sero_sel_t  sel = 3'h5;
	int         miscompares = 0;
	int         checks_done = 0;
	int         cycles = 0;
	logic [7:0] mem [512];
	logic [8:0] cur;
	// ************
	// Wiring
	// ************
	// Open drain with pull-up: controller low wins, else device drive value
	assign sda = sda_low ? 1'b0 : (sda_oe === 1'b1) ? sda_out : 1'b1;
	sero_target #(.ADDR_W(AW), .PAGE_W(4)) i_dut (
		.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .sel_pins(sel));
	sero_ctrl_model i_ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ************
	// Checking
	// ************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// ************
	// Scenarios
	// ************
	task automatic t_refuse();
		logic [7:0] bad [2];
		logic an;
		bad = '{8'h5b, 8'ha7};
		foreach (bad[k]) begin
			i_ctl.start();
			i_ctl.send_byte(bad[k], an);
			check({7'h0, an}, 8'h01);
			i_ctl.stop();
		end
	endtask : t_refuse
	// Page write; past the page end it folds back onto the same page
	// Address bit 8 rides in the device address as a page bit
	task automatic t_write(input logic [8:0] a, input int n);
		logic an;
		logic [7:0] d;
		i_ctl.start();
		i_ctl.send_byte({4'ha, sel[2:1], a[8], 1'b0}, an);
		check({7'h0, an}, 8'h00);
		i_ctl.send_byte(a[7:0], an);
		check({7'h0, an}, 8'h00);
		for (int i = 0; i < n; i++) begin
			d = a[7:0] ^ 8'h5c ^ 8'(i);
			i_ctl.send_byte(d, an);
			check({7'h0, an}, 8'h00);
			mem[{a[8:4], 4'(a[3:0] + 4'(i))}] = d;
		end
		cur = {a[8:4], 4'(a[3:0] + 4'(n))};
		i_ctl.stop();
	endtask : t_write
	task automatic t_read(input logic rnd, input logic [8:0] a, input int n);
		logic an;
		logic [7:0] d;
		i_ctl.start();
		if (rnd) begin
			i_ctl.send_byte({4'ha, sel[2:1], a[8], 1'b0}, an);
			check({7'h0, an}, 8'h00);
			i_ctl.send_byte(a[7:0], an);
			check({7'h0, an}, 8'h00);
			cur = a;
			i_ctl.start();
		end
		i_ctl.send_byte({4'ha, sel[2:1], 2'b01}, an);
		check({7'h0, an}, 8'h00);
		for (int i = 0; i < n; i++) begin
			i_ctl.recv_byte(i < n - 1, d);
			check(d, mem[cur]);
			cur = cur + 9'h001;
		end
		i_ctl.stop();
	endtask : t_read
	// ************
	// Main sequence
	// ************
	initial begin
		rstn = 1'b0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		repeat (5) @(posedge clock);
		t_refuse();
		t_write(9'h000, 4);
		t_write(9'h1f8, 17);
		t_read(1'b0, 9'h000, 2);
		t_read(1'b1, 9'h1fe, 4);
		t_read(1'b0, 9'h000, 1);
		t_refuse();
		t_read(1'b0, 9'h000, 1);
		wrap_up();
	end
	// Hang guard, about three times the expected run
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 15000) begin
			miscompares++;
			wrap_up();
		end
	end
endmodule : tb_top
`default_nettype wire
